// file: hw/fcmd_pkg.sv
// Shared opcodes, frame lengths, timing counts and CRC helpers
package fcmd_pkg;
   localparam logic [7:0]  OP_DP_ENTER     = 8'hB9;
   localparam logic [7:0]  OP_DP_RELEASE   = 8'hAB;
   localparam logic [7:0]  OP_QUAD_ENTER   = 8'h35;
   localparam logic [7:0]  OP_QUAD_RESET   = 8'hF5;
   localparam logic [7:0]  OP_RESULT_READ  = 8'h96;
   localparam logic [7:0]  OP_CRC          = 8'h9B;
   localparam logic [7:0]  SUB_CRC         = 8'h27;
   localparam logic [7:0]  OPT_DIE         = 8'hFF;
   localparam logic [7:0]  OPT_RANGE       = 8'hFE;
   localparam logic [63:0] CRC_POLY_REFL   = 64'hC96C5795D7870F42;
   localparam logic [63:0] CRC_INIT        = 64'h0000000000000000;
   // Frame lengths in link bits, result length in bytes
   localparam logic [7:0]  BITS_OPCODE     = 8'h08;
   localparam logic [7:0]  BITS_CRC_DIE    = 8'h58;
   localparam logic [7:0]  BITS_CRC_RANGE  = 8'h98;
   localparam logic [7:0]  BITS_RESULT     = 8'h40;
   localparam int          RX_BITS         = 152;
   localparam logic [4:0]  CRC_BYTES       = 5'h08;
   // Timing, times in ns, counts in 10 ns cycles
   localparam int          CLK_NS          = 10;
   localparam int          ENTER_LOW_POWER_NS = 3000;
   localparam int          WAKE_NS         = 30000;
   localparam int          RESET_RECOVERY_NS  = 40000;
   localparam logic [11:0] ENTER_LOW_POWER_CYC = 12'((ENTER_LOW_POWER_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [11:0] WAKE_CYC        = 12'((WAKE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [11:0] RESET_RECOVERY_CYC = 12'((RESET_RECOVERY_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [11:0] CS_GAP_CYC      = 12'h004;

   typedef enum logic [2:0] {
      FCMD_DP_ENTER   = 3'b000,
      FCMD_DP_RELEASE = 3'b001,
      FCMD_QUAD_ENTER = 3'b010,
      FCMD_QUAD_RESET = 3'b011,
      FCMD_CRC_DIE    = 3'b100,
      FCMD_CRC_RANGE  = 3'b101,
      FCMD_RESULT     = 3'b110
   } fcmd_op_t;

   // One data byte into a reflected CRC, low bit first
   function automatic logic [63:0] fcmd_crc_byte(input logic [63:0] crc, input logic [7:0] data);
      logic [63:0] c;
      c = crc ^ {56'h00000000000000, data};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
      end
      return c;
   endfunction : fcmd_crc_byte

   // Byte order swap, link order to word order
   function automatic logic [63:0] fcmd_rev64(input logic [63:0] x);
      logic [63:0] r;
      r = 64'h0000000000000000;
      for (int k = 0; k < 8; k++) begin
         r[8*k +: 8] = x[56-8*k +: 8];
      end
      return r;
   endfunction : fcmd_rev64
endpackage : fcmd_pkg

// file: hw/fcmd_if.sv
// Serial link between flash command logic and its host controller
`timescale 1ns/1ps
interface fcmd_if;
   logic       sclk;
   logic       cs_n;
   logic [3:0] serial_data_lines_h2d;
   logic [3:0] serial_data_lines_d2h;
   logic [3:0] serial_data_lines_oe_n;

   modport dev (input sclk, input cs_n, input serial_data_lines_h2d,
                output serial_data_lines_d2h, output serial_data_lines_oe_n);
   modport host (output sclk, output cs_n, output serial_data_lines_h2d,
                 input serial_data_lines_d2h, input serial_data_lines_oe_n);
endinterface : fcmd_if

// file: hw/fcmd_host.sv
// Host controller end: builds frames, makes the link clock, reads results
`timescale 1ns/1ps
module fcmd_host
   import fcmd_pkg::*;
#(
   parameter int HALF = 4
) (
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   fcmd_if.host             lnk,
   input  wire logic        i_cmd_valid,
   input  wire fcmd_op_t    i_cmd_op,
   input  wire logic [63:0] i_crc_expect,
   input  wire logic [31:0] i_crc_start,
   input  wire logic [31:0] i_crc_stop,
   output logic             o_cmd_ready,
   output logic             o_done,
   output logic [63:0]      o_result,
   output logic             o_quad
);
   typedef enum logic [1:0] {
      H_IDLE  = 2'b00,
      H_SHIFT = 2'b01,
      H_GAP   = 2'b10
   } fcmd_hst_t;

   fcmd_hst_t    state;
   fcmd_op_t     cur;
   logic [151:0] tx;
   logic [63:0]  rxd;
   logic [3:0]   ph;
   logic [7:0]   stp;
   logic [7:0]   tot;
   logic [7:0]   ncmd;
   logic [11:0]  gap;
   logic [3:0]   d_s1;
   logic [3:0]   d_s2;
   logic [151:0] tx_new;
   logic [7:0]   nb;
   logic         rd;

   // only fixed command set, no write enable
   always_comb begin
      tx_new = 152'h0;
      nb     = BITS_OPCODE;
      rd     = 1'b0;
      case (i_cmd_op)
         // lone opcode, select rises after it
         FCMD_DP_ENTER:   tx_new[151:144] = OP_DP_ENTER;
         // release opcode with nothing after it
         FCMD_DP_RELEASE: tx_new[151:144] = OP_DP_RELEASE;
         FCMD_QUAD_ENTER: tx_new[151:144] = OP_QUAD_ENTER;
         FCMD_QUAD_RESET: tx_new[151:144] = OP_QUAD_RESET;
         FCMD_CRC_DIE: begin
            tx_new[151:64] = {OP_CRC, SUB_CRC, OPT_DIE, fcmd_rev64(i_crc_expect)};
            nb             = BITS_CRC_DIE;
         end
         FCMD_CRC_RANGE: begin
            tx_new = {OP_CRC, SUB_CRC, OPT_RANGE, fcmd_rev64(i_crc_expect),
                      fcmd_rev64({i_crc_stop, i_crc_start})};
            nb     = BITS_CRC_RANGE;
         end
         FCMD_RESULT: begin
            tx_new[151:144] = OP_RESULT_READ;
            rd              = 1'b1;
         end
         default: tx_new = 152'h0;
      endcase
   end

   wire [7:0] cmd_steps  = o_quad ? {2'b00, nb[7:2]} : nb;
   wire [7:0] rd_steps   = rd ? (o_quad ? {2'b00, BITS_RESULT[7:2]} : BITS_RESULT) : 8'h00;
   wire       ph_rise    = (ph == 4'(HALF - 1));
   wire       ph_end     = (ph == 4'(2 * HALF - 1));
   wire [63:0] rx_next   = o_quad ? {rxd[59:0], d_s2} : {rxd[62:0], d_s2[1]};
   // select held high for the wake delay after release, the entry delay after power-down entry
   wire [11:0] gap_load  = (cur == FCMD_DP_RELEASE) ? WAKE_CYC + CS_GAP_CYC :
                           (cur == FCMD_DP_ENTER) ? ENTER_LOW_POWER_CYC + CS_GAP_CYC : CS_GAP_CYC;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         d_s1 <= 4'h0;
         d_s2 <= 4'h0;
      end else begin
         d_s1 <= lnk.serial_data_lines_d2h;
         d_s2 <= d_s1;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state                     <= H_IDLE;
         cur                       <= FCMD_DP_ENTER;
         lnk.cs_n                  <= 1'b1;
         lnk.sclk                  <= 1'b0;
         lnk.serial_data_lines_h2d <= 4'h0;
         tx                        <= 152'h0;
         rxd                       <= 64'h0;
         ph                        <= 4'h0;
         stp                       <= 8'h00;
         tot                       <= 8'h00;
         ncmd                      <= 8'h00;
         gap                       <= 12'h000;
         o_cmd_ready               <= 1'b1;
         o_done                    <= 1'b0;
         o_result                  <= 64'h0;
         o_quad                    <= 1'b0;
      end else begin
         o_done <= 1'b0;
         case (state)
            H_IDLE: if (i_cmd_valid) begin
               tx          <= tx_new;
               cur         <= i_cmd_op;
               ncmd        <= cmd_steps;
               tot         <= cmd_steps + rd_steps;
               lnk.cs_n    <= 1'b0;
               o_cmd_ready <= 1'b0;
               ph          <= 4'h0;
               stp         <= 8'h00;
               state       <= H_SHIFT;
            end
            H_SHIFT: begin
               ph <= ph + 4'h1;
               if (ph == 4'h0) begin
                  lnk.serial_data_lines_h2d <= o_quad ? tx[151:148] : {3'b000, tx[151]};
                  tx <= o_quad ? {tx[147:0], 4'h0} : {tx[150:0], 1'b0};
               end
               if (ph_rise) begin
                  lnk.sclk <= 1'b1;
               end
               if (ph_end) begin
                  lnk.sclk <= 1'b0;
                  ph       <= 4'h0;
                  if (stp >= ncmd) begin
                     rxd <= rx_next;
                  end
                  if (stp == tot - 8'h01) begin
                     gap   <= gap_load;
                     state <= H_GAP;
                  end else begin
                     stp <= stp + 8'h01;
                  end
               end
            end
            H_GAP: begin
               lnk.cs_n <= 1'b1;
               if (gap == 12'h000) begin
                  o_done      <= 1'b1;
                  o_cmd_ready <= 1'b1;
                  o_result    <= fcmd_rev64(rxd);
                  if (cur == FCMD_QUAD_ENTER) begin
                     o_quad <= 1'b1;
                  end
                  if (cur == FCMD_QUAD_RESET) begin
                     o_quad <= 1'b0;
                  end
                  state <= H_IDLE;
               end else begin
                  gap <= gap - 12'h001;
               end
            end
            default: state <= H_IDLE;
         endcase
      end
   end
endmodule : fcmd_host

// file: hw/fcmd_dev.sv
// Flash end: power-down, quad switch and CRC check command logic
//
// Operation
// - Power-down opcode alone, then select rises
// - Wait entry delay before low power
// - Refuse power-down during array write
// - No error flags, write latch frozen
// - Power-down ignores all but release, resets
// - Release opcode alone; extra clocks void it
// - Standby after wake delay, select high
// - Reset leaves power-down at once; recovery time follows
// - Quad enter and leave act immediately
// - Host sends quad commands without write enable
// - Checker uses 64-bit ECMA polynomial
// - Low bit first, zero initial value
// - Compare with expected, report fail flag
// - Store result only on fail; read back
// - Result buffer cleared at check start
// - Result buffer cleared on any reset
// - Read walks bytes, zeros past buffer end
// - Whole die sequence: opcode, sub, FFh, CRC
// - Range sequence adds start, stop addresses
// - Range covers start through stop byte
// - Check starts when select rises
`timescale 1ns/1ps
module fcmd_dev
   import fcmd_pkg::*;
#(
   parameter logic [31:0] DIE_BYTES = 32'h0100_0000
) (
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   fcmd_if.dev              lnk,
   input  wire logic        i_soft_reset,
   input  wire logic        i_write_busy,
   input  wire logic [7:0]  i_rd_data,
   input  wire logic        i_rd_valid,
   output logic             o_rd_req,
   output logic [31:0]      o_rd_addr,
   output logic             o_busy,
   output logic             o_crc_fail,
   output logic             o_deep_pd,
   output logic             o_low_power,
   output logic             o_quad
);
   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_DP_ENTER = 3'b001,
      ST_DP       = 3'b010,
      ST_WAKE     = 3'b011,
      ST_RECOVER  = 3'b100,
      ST_CRC      = 3'b101
   } fcmd_st_t;

   fcmd_st_t state;
   logic [11:0]  timer;
   logic [63:0]  res_buf;
   logic [63:0]  crc;
   logic [63:0]  expect_crc;
   logic [31:0]  end_addr;
   logic         cs_s1;
   logic         cs_s2;
   logic         cs_s3;

   // Link side, sampled on the link clock or on the select fall
   logic         frm_tog;
   logic         frm_seen;
   logic         frm_quad;
   logic         frm_dp;
   logic [63:0]  frm_res;
   logic [7:0]   bits;
   logic [7:0]   op;
   logic [RX_BITS-1:0] rx;

   // Snapshot of core state at frame start; held until the next frame start or an i_reset_n reset
   always_ff @(negedge lnk.cs_n or negedge i_reset_n) begin
      if (!i_reset_n) begin
         frm_tog  <= 1'b0;
         frm_quad <= 1'b0;
         frm_dp   <= 1'b0;
         frm_res  <= 64'h0;
      end else begin
         frm_tog  <= ~frm_tog;
         frm_quad <= o_quad;
         frm_dp   <= o_deep_pd;
         frm_res  <= res_buf;
      end
   end

   wire        first    = (frm_seen != frm_tog);
   wire [3:0]  step     = frm_quad ? 4'h4 : 4'h1;
   wire [8:0]  sum      = {1'b0, first ? 8'h00 : bits} + {5'h00, step};
   wire [7:0]  next_bits = sum[8] ? 8'hFF : sum[7:0];
   wire [RX_BITS-1:0] next_rx = frm_quad ? {rx[RX_BITS-5:0], lnk.serial_data_lines_h2d}
                                         : {rx[RX_BITS-2:0], lnk.serial_data_lines_h2d[0]};

   always_ff @(posedge lnk.sclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         frm_seen <= 1'b0;
         bits     <= 8'h00;
         op       <= 8'h00;
         rx       <= '0;
      end else begin
         frm_seen <= frm_tog;
         bits     <= next_bits;
         rx       <= next_rx;
         if (first) begin
            op <= 8'h00;
         end
         if (next_bits == BITS_OPCODE) begin
            op <= next_rx[7:0];
         end
      end
   end

   // Result read-out, shifted on the falling link edge
   wire        out_rst  = lnk.cs_n | ~i_reset_n;
   wire [7:0]  out_pos  = bits - BITS_OPCODE;
   wire [4:0]  ridx     = out_pos[7:3];
   wire        rd_act   = !frm_dp && (op == OP_RESULT_READ) && (bits >= BITS_OPCODE);
   // byte by byte, zero past stored bytes
   wire [7:0]  rbyte    = (ridx < CRC_BYTES) ? frm_res[{ridx[2:0], 3'b000} +: 8] : 8'h00;
   // low byte first, high bit first within
   wire [3:0]  nib      = out_pos[2] ? rbyte[3:0] : rbyte[7:4];
   wire        obit     = rbyte[3'h7 - out_pos[2:0]];

   always_ff @(negedge lnk.sclk or posedge out_rst) begin
      if (out_rst) begin
         lnk.serial_data_lines_d2h  <= 4'h0;
         lnk.serial_data_lines_oe_n <= 4'hF;
      end else if (rd_act) begin
         lnk.serial_data_lines_d2h  <= frm_quad ? nib : {2'b00, obit, 1'b0};
         lnk.serial_data_lines_oe_n <= frm_quad ? 4'h0 : 4'hD;
      end else begin
         lnk.serial_data_lines_d2h  <= 4'h0;
         lnk.serial_data_lines_oe_n <= 4'hF;
      end
   end

   // Core side: select synchroniser, frame end on its rise
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_s3 <= 1'b1;
      end else begin
         cs_s1 <= lnk.cs_n;
         cs_s2 <= cs_s1;
         cs_s3 <= cs_s2;
      end
   end

   // Frame contents are quiet once select is high
   wire        frame_end = cs_s2 & ~cs_s3;
   wire        is_op8    = (bits == BITS_OPCODE);
   wire [7:0]  op8       = rx[7:0];
   // full die frame length and header
   wire        crc_die   = (bits == BITS_CRC_DIE) && (rx[87:64] == {OP_CRC, SUB_CRC, OPT_DIE});
   wire        crc_rng   = (bits == BITS_CRC_RANGE) && (rx[151:128] == {OP_CRC, SUB_CRC, OPT_RANGE});
   wire [63:0] tail_w    = fcmd_rev64(rx[63:0]);
   wire [63:0] exp_rng   = fcmd_rev64(rx[127:64]);
   wire [31:0] rng_start = tail_w[31:0];
   wire [31:0] rng_stop  = (tail_w[63:32] < tail_w[31:0]) ? tail_w[31:0] : tail_w[63:32];
   // next value of the running check
   wire [63:0] crc_next  = fcmd_crc_byte(crc, i_rd_data);
   wire        tdone     = (timer == 12'h001);

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         // power-up lands in standby, buffer clear
         state       <= ST_IDLE;
         timer       <= 12'h000;
         res_buf     <= 64'h0;
         crc         <= CRC_INIT;
         expect_crc  <= 64'h0;
         end_addr    <= 32'h0;
         o_rd_req    <= 1'b0;
         o_rd_addr   <= 32'h0;
         o_busy      <= 1'b0;
         o_crc_fail  <= 1'b0;
         o_deep_pd   <= 1'b0;
         o_low_power <= 1'b0;
         o_quad      <= 1'b0;
      end else if (i_soft_reset) begin
         state       <= ST_RECOVER;
         timer       <= RESET_RECOVERY_CYC;
         res_buf     <= 64'h0;
         o_rd_req    <= 1'b0;
         o_busy      <= 1'b0;
         o_crc_fail  <= 1'b0;
         o_deep_pd   <= 1'b0;
         o_low_power <= 1'b0;
         o_quad      <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: if (frame_end) begin
               // refused while the array is writing
               if (is_op8 && op8 == OP_DP_ENTER && !i_write_busy) begin
                  state     <= ST_DP_ENTER;
                  timer     <= ENTER_LOW_POWER_CYC;
                  o_deep_pd <= 1'b1;
               end
               if (is_op8 && op8 == OP_QUAD_ENTER) begin
                  o_quad <= 1'b1;
               end
               if (is_op8 && op8 == OP_QUAD_RESET) begin
                  o_quad <= 1'b0;
               end
               if (crc_die || crc_rng) begin
                  state      <= ST_CRC;
                  res_buf    <= 64'h0;
                  crc        <= CRC_INIT;
                  o_crc_fail <= 1'b0;
                  o_busy     <= 1'b1;
                  o_rd_req   <= 1'b1;
                  expect_crc <= crc_rng ? exp_rng : tail_w;
                  o_rd_addr  <= crc_rng ? rng_start : 32'h0;
                  end_addr   <= crc_rng ? rng_stop : DIE_BYTES - 32'h1;
               end
            end
            // low power only after the entry delay
            ST_DP_ENTER: begin
               timer <= timer - 12'h001;
               if (tdone) begin
                  state       <= ST_DP;
                  o_low_power <= 1'b1;
               end
            end
            // only a clean release is heard
            ST_DP: if (frame_end && is_op8 && op8 == OP_DP_RELEASE) begin
               state       <= ST_WAKE;
               timer       <= WAKE_CYC;
               o_low_power <= 1'b0;
            end
            ST_WAKE: begin
               timer <= timer - 12'h001;
               if (tdone) begin
                  state     <= ST_IDLE;
                  o_deep_pd <= 1'b0;
               end
            end
            ST_RECOVER: begin
               timer <= timer - 12'h001;
               if (tdone) begin
                  state <= ST_IDLE;
               end
            end
            ST_CRC: if (i_rd_valid) begin
               crc <= crc_next;
               if (o_rd_addr == end_addr) begin
                  state      <= ST_IDLE;
                  o_rd_req   <= 1'b0;
                  o_busy     <= 1'b0;
                  o_crc_fail <= (crc_next != expect_crc);
                  res_buf    <= (crc_next != expect_crc) ? crc_next : 64'h0;
               end else begin
                  o_rd_addr <= o_rd_addr + 32'h1;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule : fcmd_dev

// file: sim/fcmd_chk.sv
// Assertions on the link and the flash end's status flags
`timescale 1ns/1ps
module fcmd_chk (
   input  wire logic       i_clk,
   input  wire logic       i_reset_n,
   input  wire logic       sclk,
   input  wire logic       cs_n,
   input  wire logic [3:0] serial_data_lines_oe_n,
   input  wire logic       i_soft_reset,
   input  wire logic       o_busy,
   input  wire logic       o_rd_req,
   input  wire logic       o_crc_fail,
   input  wire logic       o_deep_pd,
   input  wire logic       o_low_power,
   input  wire logic       o_quad
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   sequence dp_start;
      $rose(o_deep_pd);
   endsequence
   sequence lp_reached;
      ##[295:305] $rose(o_low_power);
   endsequence
   dp_delay_a: assert property (dp_start |-> lp_reached)
      else $error("low power state not reached on time");
   lp_inside_a: assert property (o_low_power |-> o_deep_pd)
      else $error("low power outside power-down");
   link_idle_a: assert property (cs_n |-> serial_data_lines_oe_n == 4'hF && !sclk)
      else $error("link not idle while deselected");
   rd_busy_a: assert property (o_rd_req |-> o_busy)
      else $error("array read outside busy");
   dp_quiet_a: assert property (o_deep_pd |-> !o_busy)
      else $error("check ran in power-down");
   quad_switch_a: assert property ($changed(o_quad) |-> $past(cs_n, 2))
      else $error("protocol changed inside a frame");
   crc_start_a: assert property ($rose(o_busy) |-> cs_n && !o_crc_fail)
      else $error("check started badly");
   fail_flag_a: assert property ($changed(o_crc_fail) |-> $fell(o_busy) || $rose(o_busy) || $past(i_soft_reset))
      else $error("fail flag changed without cause");
endmodule : fcmd_chk

// file: sim/flash_lowpower_quad_crc_cmds_tb_top.sv
// Bench joining host and flash ends over the serial link
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module flash_lowpower_quad_crc_cmds_tb_top;
   import fcmd_pkg::*;
   logic        i_clk      = 1'b0;
   logic        i_reset_n  = 1'b1;
   logic        cmd_valid  = 1'b0;
   fcmd_op_t    cmd_op     = FCMD_DP_ENTER;
   logic [63:0] crc_expect = 64'h0;
   logic [31:0] crc_start  = 32'h0;
   logic [31:0] crc_stop   = 32'h0;
   logic        soft_reset = 1'b0;
   logic        write_busy = 1'b0;
   logic [7:0]  rd_data    = 8'h00;
   logic        rd_valid   = 1'b0;
   logic        cmd_ready, done, h_quad, rd_req, busy, crc_fail, deep_pd, low_power, d_quad;
   logic [63:0] result;
   logic [31:0] rd_addr;
   int          n_errors     = 0;
   int          total_checks = 0;
   int          cycles       = 0;
   fcmd_if lnk_if ();
   fcmd_host #(.HALF(4)) u_fcmd_host (.i_clk(i_clk), .i_reset_n(i_reset_n), .lnk(lnk_if.host),
      .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op), .i_crc_expect(crc_expect), .i_crc_start(crc_start),
      .i_crc_stop(crc_stop), .o_cmd_ready(cmd_ready), .o_done(done), .o_result(result), .o_quad(h_quad));
   fcmd_dev #(.DIE_BYTES(32'h0000_0010)) u_fcmd_dev (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .lnk(lnk_if.dev), .i_soft_reset(soft_reset), .i_write_busy(write_busy), .i_rd_data(rd_data),
      .i_rd_valid(rd_valid), .o_rd_req(rd_req), .o_rd_addr(rd_addr), .o_busy(busy), .o_crc_fail(crc_fail),
      .o_deep_pd(deep_pd), .o_low_power(low_power), .o_quad(d_quad));
   fcmd_chk u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .sclk(lnk_if.sclk), .cs_n(lnk_if.cs_n),
      .serial_data_lines_oe_n(lnk_if.serial_data_lines_oe_n), .i_soft_reset(soft_reset), .o_busy(busy),
      .o_rd_req(rd_req), .o_crc_fail(crc_fail), .o_deep_pd(deep_pd), .o_low_power(low_power),
      .o_quad(d_quad));

   always #5 i_clk = ~i_clk;

   function automatic logic [7:0] mem_byte(input logic [31:0] a);
      return a[7:0] ^ 8'hA5;
   endfunction : mem_byte

   // Bitwise reflected CRC, low bit first, zero start
   function automatic logic [63:0] crc_ref(input logic [31:0] first, input logic [31:0] last);
      logic [63:0] c;
      logic [7:0]  d;
      c = 64'h0;
      for (logic [31:0] a = first; a <= last; a++) begin
         d = mem_byte(a);
         for (int i = 0; i < 8; i++) begin
            c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
         end
      end
      return c;
   endfunction : crc_ref

   // Array answers with a stall every other cycle
   always @(negedge i_clk) begin
      rd_valid <= rd_req & cycles[0];
      rd_data  <= mem_byte(rd_addr);
   end

   task automatic end_of_test();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test

   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 60000) begin
         n_errors++;
         end_of_test();
      end
   end

   // One host request, then wait for its end and for the check to finish
   task automatic run(input fcmd_op_t op, input logic [63:0] ex, input logic [31:0] st, input logic [31:0] sp);
      int k;
      @(negedge i_clk);
      cmd_op = op;
      crc_expect = ex;
      crc_start = st;
      crc_stop = sp;
      cmd_valid = 1'b1;
      @(negedge i_clk);
      cmd_valid = 1'b0;
      `CHK({cmd_ready, lnk_if.cs_n}, 2'b00)
      k = 0;
      while (done !== 1'b1 && k < 5000) begin
         @(negedge i_clk);
         k++;
      end
      @(negedge i_clk);
      while (busy === 1'b1 && k < 5000) begin
         @(negedge i_clk);
         k++;
      end
      if (k >= 5000) begin
         n_errors++;
         end_of_test();
      end
   endtask : run

   task automatic t_crc();
      run(FCMD_CRC_DIE, crc_ref(32'h0, 32'hF), 32'h0, 32'h0);
      `CHK(crc_fail, 1'b0)
      `CHK(rd_addr, 32'h0000000F)
      run(FCMD_CRC_RANGE, 64'h0123456789ABCDEF, 32'h3, 32'h9);
      `CHK(crc_fail, 1'b1)
      `CHK(rd_addr, 32'h00000009)
      run(FCMD_RESULT, 64'h0, 32'h0, 32'h0);
      `CHK(result, crc_ref(32'h3, 32'h9))
      run(FCMD_CRC_RANGE, crc_ref(32'h5, 32'h5), 32'h5, 32'h5);
      `CHK(crc_fail, 1'b0)
      run(FCMD_RESULT, 64'h0, 32'h0, 32'h0);
      `CHK(result, 64'h0)
   endtask : t_crc

   task automatic t_dp();
      @(negedge i_clk);
      write_busy = 1'b1;
      run(FCMD_DP_ENTER, 64'h0, 32'h0, 32'h0);
      `CHK(deep_pd, 1'b0)
      write_busy = 1'b0;
      run(FCMD_DP_ENTER, 64'h0, 32'h0, 32'h0);
      `CHK(deep_pd, 1'b1)
      repeat (10) @(negedge i_clk);
      `CHK(low_power, 1'b1)
      run(FCMD_QUAD_ENTER, 64'h0, 32'h0, 32'h0);
      `CHK(d_quad, 1'b0)
      // Host switched on its own; bring it back to single lines
      run(FCMD_QUAD_RESET, 64'h0, 32'h0, 32'h0);
      `CHK({h_quad, low_power}, 2'b01)
      run(FCMD_DP_RELEASE, 64'h0, 32'h0, 32'h0);
      `CHK(low_power, 1'b0)
      repeat (20) @(negedge i_clk);
      `CHK(deep_pd, 1'b0)
      run(FCMD_QUAD_ENTER, 64'h0, 32'h0, 32'h0);
      `CHK({d_quad, h_quad}, 2'h3)
      run(FCMD_QUAD_RESET, 64'h0, 32'h0, 32'h0);
      `CHK(d_quad, 1'b0)
   endtask : t_dp

   task automatic t_reset();
      run(FCMD_CRC_RANGE, 64'h0, 32'h0, 32'h2);
      `CHK(crc_fail, 1'b1)
      soft_reset = 1'b1;
      @(negedge i_clk);
      soft_reset = 1'b0;
      `CHK(crc_fail, 1'b0)
      repeat (4010) @(negedge i_clk);
      run(FCMD_RESULT, 64'h0, 32'h0, 32'h0);
      `CHK(result, 64'h0)
      run(FCMD_DP_ENTER, 64'h0, 32'h0, 32'h0);
      i_reset_n = 1'b0;
      repeat (3) @(negedge i_clk);
      i_reset_n = 1'b1;
      repeat (4) @(negedge i_clk);
      `CHK(deep_pd, 1'b0)
      run(FCMD_QUAD_ENTER, 64'h0, 32'h0, 32'h0);
      `CHK(d_quad, 1'b1)
   endtask : t_reset

   initial begin
      // Reset falls as a real edge so link-clocked flops clear too
      @(negedge i_clk);
      i_reset_n = 1'b0;
      repeat (10) @(negedge i_clk);
      i_reset_n = 1'b1;
      repeat (4) @(negedge i_clk);
      t_crc();
      t_dp();
      t_reset();
      end_of_test();
   end
endmodule : flash_lowpower_quad_crc_cmds_tb_top
